// file: bench/host_serial_model.sv
// host controller model driving the serial configuration port
`timescale 1ns/100ps
module host_serial_model (
    output logic sclk,
    output logic select_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    logic hdrv = 1'b0;
    logic hen = 1'b0;
    logic long_m = 1'b1;
    logic lsb_m = 1'b0;
    logic bidir_m = 1'b0;
    // a released data pin shows the inverse of the last host bit
    assign sdio_in = sdio_oe ? sdio_out : (hen ? hdrv : ~hdrv);
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
    end
    task automatic defaults();
        long_m = 1'b1;
        lsb_m = 1'b0;
        bidir_m = 1'b0;
    endtask : defaults
    // clock only used while reset is carried into the serial domain
    task automatic pulses(input int n);
        repeat (n) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
    endtask : pulses
    // data changes after the falling edge, read data is taken just before the rising edge
    task automatic tick(input logic b, output logic r);
        hdrv = b;
        #40;
        r = bidir_m ? sdio_in : (serial_out_oe ? serial_out_pin : ~serial_out_pin);
        sclk = 1'b1;
        #40;
        sclk = 1'b0;
    endtask : tick
    task automatic xfer(input logic rd, input logic [12:0] addr, input int nb, input logic [15:0] wd,
                        output logic [15:0] rdat);
        logic [15:0] insn;
        logic r;
        int len;
        int idx;
        len = long_m ? 16 : 8;
        insn = long_m ? {rd, 2'(nb - 1), addr} : {8'h00, rd, 2'(nb - 1), addr[4:0]};
        rdat = 16'h0000;
        hen = 1'b1;
        select_n = 1'b0;
        for (int i = 0; i < len; i++) begin
            tick(insn[lsb_m ? i : len - 1 - i], r);
        end
        hen = !rd;
        for (int i = 0; i < 8 * nb; i++) begin
            idx = 8 * (i / 8) + (lsb_m ? i % 8 : 7 - i % 8);
            tick(wd[idx], r);
            rdat[idx] = r;
        end
        #40 select_n = 1'b1;
        hen = 1'b0;
        if (!rd && addr == 13'h0000) begin
            long_m = wd[5] | wd[4];
            lsb_m = wd[6] & ~wd[5];
            bidir_m = wd[7] & ~wd[5];
        end
        #80;
    endtask : xfer
endmodule : host_serial_model

// file: bench/pll_serial_config_registers_tb_top.sv
// testbench of the pll configuration register bank
`timescale 1ns/100ps
module pll_serial_config_registers_tb_top;
    import pll_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic lock_detect = 1'b0;
    logic pfd_tick = 1'b0;
    logic sclk, select_n, sdio_in, sdio_out, sdio_oe, serial_out_pin, serial_out_oe, reference_loss_detect;
    logic [5:0] swallow_count;
    logic [12:0] main_feedback_count;
    pump_mode_t pump_mode;
    logic [7:0] mdl [0:15];
    logic [7:0] modes [6] = '{8'h50, 8'h40, 8'h00, 8'h80, 8'hd0, 8'h90};
    logic [15:0] rdat;
    logic [15:0] rv;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    integer seed = 52;

    always #50 core_clk = ~core_clk;

    pll_serial_config_registers dut (.core_clk(core_clk), .reset(reset), .sclk(sclk), .select_n(select_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .lock_detect(lock_detect), .pfd_tick(pfd_tick),
        .swallow_count(swallow_count), .main_feedback_count(main_feedback_count), .pump_mode(pump_mode),
        .reference_loss_detect(reference_loss_detect));

    host_serial_model host (.sclk(sclk), .select_n(select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

    task automatic note(input logic ok, input string what);
        tests_run++;
        if (!ok) begin
            n_errors++;
            $display("ERROR at %0t: %s mismatch", $time, what);
        end
    endtask : note
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        note(got === exp, "read data");
    endtask : check_rd
    task automatic check_outs();
        repeat (12) @(negedge core_clk);
        note({swallow_count, main_feedback_count, pump_mode} ===
             {mdl[4][5:0], mdl[5][4:0], mdl[6], mdl[8][1:0]}, "configuration output");
    endtask : check_outs
    task automatic check_lor(input logic exp);
        note(reference_loss_detect === exp, "loss detect");
    endtask : check_lor
    task automatic check_pin(input logic got);
        note(got === 1'b0, "pin enable");
    endtask : check_pin

    function automatic logic [7:0] mask(input int a);
        case (a)
            0: return 8'hd0;
            4: return 8'h3f;
            5: return 8'h1f;
            6, 8: return 8'hff;
            7: return 8'h64;
            default: return 8'h00;
        endcase
    endfunction : mask
    task automatic mdl_reset();
        mdl = '{default: 8'h00};
        mdl[0] = 8'h10;
    endtask : mdl_reset
    task automatic do_reset();
        @(negedge core_clk);
        reset = 1'b1;
        lock_detect = 1'b0;
        fork
            repeat (10) @(negedge core_clk);
            host.pulses(6);
        join
        reset = 1'b0;
        host.pulses(4);
        host.defaults();
        mdl_reset();
    endtask : do_reset
    task automatic wr(input int a, input int nb, input logic [15:0] d);
        int step;
        step = host.lsb_m ? 1 : -1;
        host.xfer(1'b0, 13'(a), nb, d, rdat);
        for (int j = 0; j < nb; j++) begin
            if (a + j * step == 0 && d[5]) mdl_reset();
            else mdl[a + j * step] = d[8 * j +: 8] & mask(a + j * step);
        end
    endtask : wr
    task automatic rd_chk(input int a);
        host.xfer(1'b1, 13'(a), 1, 16'h0000, rdat);
        check_rd(rdat[7:0], mdl[a]);
    endtask : rd_chk
    task automatic pfd_pulses(input int n);
        repeat (n) begin
            pfd_tick = 1'b1;
            repeat (3) @(negedge core_clk);
            pfd_tick = 1'b0;
            repeat (3) @(negedge core_clk);
        end
    endtask : pfd_pulses
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // only one serial output may drive, and only the one the mode selects
    always @(negedge core_clk) begin
        if (!reset) check_pin(host.bidir_m ? serial_out_oe : sdio_oe);
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        mdl_reset();
        do_reset();
        check_outs();
        check_lor(1'b0);
        for (int a = 0; a < 10; a++) rd_chk(a);
        wr(2, 1, 16'h00ff);
        rd_chk(2);
        for (int i = 0; i < 20; i++) begin
            rv = 16'($random(seed));
            if (i % 5 == 4) rv[1:0] = 2'(i / 5);
            wr(4 + i % 5, 1, rv);
            rd_chk(4 + i % 5);
            check_outs();
        end
        foreach (modes[m]) begin
            wr(0, 1, {8'h00, modes[m]});
            rv = 16'($random(seed));
            wr(host.lsb_m ? 5 : 6, 2, rv);
            rd_chk(0);
            rd_chk(5);
            rd_chk(6);
            check_outs();
        end
        wr(0, 1, 16'h00e0);
        for (int a = 0; a < 9; a++) rd_chk(a);
        check_outs();
        for (int s = 0; s < 4; s++) begin
            do_reset();
            wr(7, 1, 16'h0004 | 16'(s << 5));
            @(negedge core_clk);
            lock_detect = 1'b1;
            repeat (5) @(negedge core_clk);
            pfd_pulses((3 << s) - 1);
            repeat (8) @(negedge core_clk);
            check_lor(1'b0);
            pfd_pulses(1);
            repeat (4) @(negedge core_clk);
            check_lor(1'b1);
            wr(7, 1, 16'h0000);
            repeat (8) @(negedge core_clk);
            check_lor(1'b0);
        end
        give_verdict();
    end
endmodule : pll_serial_config_registers_tb_top

// file: hdl/pll_cfg_map.svh
// register addresses, field positions, reset values and timing counts of the pll configuration port
`ifndef PLL_CFG_MAP_SVH
`define PLL_CFG_MAP_SVH

`define ADDR_SPCFG 13'h0000
`define ADDR_SWALLOW 13'h0004
`define ADDR_FB_HIGH 13'h0005
`define ADDR_FB_LOW 13'h0006
`define ADDR_LOR_CTL 13'h0007
`define ADDR_PUMP_CTL 13'h0008

`define SPCFG_LONG 4
`define SPCFG_SOFT_RST 5
`define SPCFG_LSB_FIRST 6
`define SPCFG_BIDIR 7
`define SWALLOW_MSB 5
`define FB_MSB 12
`define FB_HIGH_LSB 8
`define FB_HIGH_FIELD_MSB 4
`define FB_LOW_MSB 7
`define LOR_EN_BIT 2
`define LOR_DLY_MSB 6
`define LOR_DLY_LSB 5
`define PUMP_MODE_MSB 1
`define LOR_USED_MASK 8'h64
`define SWALLOW_USED_MASK 8'h3f

`define LONG_INSN_RESET 1'b1
`define LSB_FIRST_RESET 1'b0
`define BIDIR_RESET 1'b0
`define SWALLOW_RESET 6'h00
`define FB_RESET 13'h0000
`define LOR_EN_RESET 1'b0
`define LOR_DLY_RESET 2'h0
`define PUMP_CTL_RESET 8'h00

`define INSN_LONG_LAST 4'hf
`define INSN_SHORT_LAST 4'h7
`define LONG_RW_BIT 15
`define LONG_W_MSB 14
`define LONG_W_LSB 13
`define LONG_ADDR_MSB 12
`define SHORT_RW_BIT 7
`define SHORT_W_MSB 6
`define SHORT_W_LSB 5
`define SHORT_ADDR_MSB 4
`define STREAM_CODE 2'h3
`define BYTE_LAST 4'h7
`define LOR_WAIT_BASE 5'h03

`endif

// file: hdl/pll_cfg_pkg.sv
// types shared by the pll configuration port
package pll_cfg_pkg;
`include "pll_cfg_map.svh"

    typedef enum logic [1:0] {
        PUMP_TRISTATE = 2'h0,
        PUMP_UP = 2'h1,
        PUMP_DOWN = 2'h2,
        PUMP_NORMAL = 2'h3
    } pump_mode_t;

    typedef enum logic [1:0] {ST_INSN, ST_DATA, ST_DONE} frame_phase_t;

    typedef struct packed {
        logic valid;
        logic [12:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic long_insn;
        logic lsb_first;
        logic bidir;
    } port_mode_t;

    typedef struct packed {
        logic [5:0] swallow;
        logic [12:0] feedback;
        logic lor_en;
        logic [1:0] lor_delay;
        logic [7:0] pump_ctl;
    } cfg_image_t;

    typedef struct packed {
        logic out;
        logic sdo_oe;
        logic sdio_oe;
    } serial_drive_t;

    typedef struct packed {
        frame_phase_t phase;
        logic [3:0] cnt;
        logic [15:0] insn;
        logic [12:0] addr;
        logic is_read;
        logic stream;
        logic [1:0] left;
        logic [7:0] dbyte;
        serial_drive_t drv;
    } frame_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        port_mode_t mode;
        cfg_image_t regs;
        logic toggle;
    } link_t;

    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic lock_s1;
        logic lock_s2;
        logic pfd_s1;
        logic pfd_s2;
        logic pfd_s3;
        cfg_image_t img;
        logic lock_seen;
        logic [4:0] arm_cnt;
        logic armed;
    } core_t;

    localparam port_mode_t MODE_DEFAULT = '{`LONG_INSN_RESET, `LSB_FIRST_RESET, `BIDIR_RESET};
    localparam cfg_image_t IMAGE_DEFAULT = '{`SWALLOW_RESET, `FB_RESET, `LOR_EN_RESET, `LOR_DLY_RESET,
                                             `PUMP_CTL_RESET};
endpackage : pll_cfg_pkg

// file: hdl/pll_serial_config_registers.sv
// pll configuration register bank behind the serial control port
`timescale 1ns/100ps

module pll_serial_config_registers
    import pll_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic lock_detect,
    input wire logic pfd_tick,
    output logic [5:0] swallow_count,
    output logic [12:0] main_feedback_count,
    output pump_mode_t pump_mode,
    output logic reference_loss_detect
);
    function automatic logic [4:0] delay_cycles(input logic [1:0] code);
        return 5'(`LOR_WAIT_BASE << code);
    endfunction : delay_cycles

    function automatic logic [7:0] read_reg(input logic [12:0] a, input port_mode_t m, input cfg_image_t r);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `ADDR_SPCFG: begin
                d[`SPCFG_LONG] = m.long_insn;
                d[`SPCFG_LSB_FIRST] = m.lsb_first;
                d[`SPCFG_BIDIR] = m.bidir;
            end
            `ADDR_SWALLOW: d[`SWALLOW_MSB:0] = r.swallow;
            `ADDR_FB_HIGH: d[`FB_HIGH_FIELD_MSB:0] = r.feedback[`FB_MSB:`FB_HIGH_LSB];
            `ADDR_FB_LOW: d = r.feedback[`FB_LOW_MSB:0];
            `ADDR_LOR_CTL: begin
                d[`LOR_EN_BIT] = r.lor_en;
                d[`LOR_DLY_MSB:`LOR_DLY_LSB] = r.lor_delay;
            end
            `ADDR_PUMP_CTL: d = r.pump_ctl;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_reg

    link_t l;
    link_t next_l;
    core_t c;
    core_t next_c;
    logic [12:0] rd_addr;
    logic [7:0] rd_data;
    reg_write_t wr;
    serial_drive_t drv;

    serial_frame_engine engine (
        .sclk(sclk),
        .select_n(select_n),
        .sdio_in(sdio_in),
        .mode(l.mode),
        .rd_data(rd_data),
        .rd_addr(rd_addr),
        .wr(wr),
        .drv(drv)
    );

    assign rd_data = read_reg(rd_addr, l.mode, l.regs);

    // serial clock domain: the register file, written on the edge that carries the last data bit
    always_comb begin
        next_l = l;
        next_l.rst_s1 = reset;
        next_l.rst_s2 = l.rst_s1;
        if (l.rst_s2) begin
            // the core side also clears its toggle chain in reset, so both ends start level and agree
            next_l.toggle = 1'b0;
            next_l.mode = MODE_DEFAULT;
            next_l.regs = IMAGE_DEFAULT;
        end else if (wr.valid) begin
            // each write is announced to the core domain by flipping the toggle
            next_l.toggle = !l.toggle;
            case (wr.addr)
                `ADDR_SPCFG: begin
                    if (wr.data[`SPCFG_SOFT_RST]) begin
                        next_l.mode = MODE_DEFAULT;
                        next_l.regs = IMAGE_DEFAULT;
                    end else begin
                        next_l.mode.long_insn = wr.data[`SPCFG_LONG];
                        next_l.mode.lsb_first = wr.data[`SPCFG_LSB_FIRST];
                        next_l.mode.bidir = wr.data[`SPCFG_BIDIR];
                    end
                end
                `ADDR_SWALLOW: next_l.regs.swallow = wr.data[`SWALLOW_MSB:0];
                `ADDR_FB_HIGH: next_l.regs.feedback[`FB_MSB:`FB_HIGH_LSB] = wr.data[`FB_HIGH_FIELD_MSB:0];
                `ADDR_FB_LOW: next_l.regs.feedback[`FB_LOW_MSB:0] = wr.data;
                `ADDR_LOR_CTL: begin
                    next_l.regs.lor_en = wr.data[`LOR_EN_BIT];
                    next_l.regs.lor_delay = wr.data[`LOR_DLY_MSB:`LOR_DLY_LSB];
                end
                `ADDR_PUMP_CTL: next_l.regs.pump_ctl = wr.data;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sclk) begin
        l <= next_l;
    end

    // core domain: captures the register image when the synchronised toggle moves;
    // the image stays still for at least eight serial clocks, longer than the capture takes
    always_comb begin
        next_c = c;
        next_c.tog_s1 = l.toggle;
        next_c.tog_s2 = c.tog_s1;
        next_c.tog_s3 = c.tog_s2;
        next_c.lock_s1 = lock_detect;
        next_c.lock_s2 = c.lock_s1;
        next_c.pfd_s1 = pfd_tick;
        next_c.pfd_s2 = c.pfd_s1;
        next_c.pfd_s3 = c.pfd_s2;
        if (c.tog_s3 != c.tog_s2) begin
            next_c.img = l.regs;
        end
        if (!c.img.lor_en) begin
            next_c.lock_seen = 1'b0;
            next_c.arm_cnt = 5'h00;
            next_c.armed = 1'b0;
        end else begin
            if (c.lock_s2) begin
                next_c.lock_seen = 1'b1;
            end
            if (c.lock_seen && !c.armed && c.pfd_s2 && !c.pfd_s3) begin
                next_c.arm_cnt = 5'(c.arm_cnt + 5'h01);
                if (next_c.arm_cnt == delay_cycles(c.img.lor_delay)) begin
                    next_c.armed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            c <= '0;
            c.img <= IMAGE_DEFAULT;
        end else begin
            c <= next_c;
        end
    end

    assign sdio_out = drv.out;
    assign sdio_oe = drv.sdio_oe;
    assign serial_out_pin = drv.out;
    assign serial_out_oe = drv.sdo_oe;
    assign swallow_count = c.img.swallow;
    assign main_feedback_count = c.img.feedback;
    assign pump_mode = pump_mode_t'(c.img.pump_ctl[`PUMP_MODE_MSB:0]);
    assign reference_loss_detect = c.armed;

    sequence cfg_write_s;
        wr.valid && wr.addr == `ADDR_SPCFG;
    endsequence

    cfg_immediate_a: assert property (@(posedge sclk) disable iff (l.rst_s2)
        (cfg_write_s and !wr.data[`SPCFG_SOFT_RST]) |=>
            l.mode.lsb_first == $past(wr.data[`SPCFG_LSB_FIRST]) && l.mode.bidir == $past(wr.data[`SPCFG_BIDIR]))
        else $error("port configuration write did not act on the next edge");
    long_default_a: assert property (@(posedge sclk)
        l.rst_s2 |=> l.mode.long_insn && !l.mode.lsb_first && !l.mode.bidir)
        else $error("port mode not at default after reset");
    soft_reset_a: assert property (@(posedge sclk) disable iff (l.rst_s2)
        (cfg_write_s and wr.data[`SPCFG_SOFT_RST]) |=> l.regs == IMAGE_DEFAULT && l.mode == MODE_DEFAULT)
        else $error("soft reset left a register changed");
    swallow_field_a: assert property (@(posedge sclk) disable iff (l.rst_s2)
        (wr.valid && wr.addr == `ADDR_SWALLOW) |=> l.regs.swallow == $past(wr.data[`SWALLOW_MSB:0]))
        else $error("swallow count not written");
    feedback_split_a: assert property (@(posedge sclk) disable iff (l.rst_s2)
        (wr.valid && wr.addr == `ADDR_FB_HIGH) |=>
            l.regs.feedback[`FB_MSB:`FB_HIGH_LSB] == $past(wr.data[`FB_HIGH_FIELD_MSB:0])
            && $stable(l.regs.feedback[`FB_LOW_MSB:0]))
        else $error("feedback count high part misplaced");
    unused_zero_a: assert property (@(posedge sclk) disable iff (l.rst_s2)
        (rd_addr == `ADDR_LOR_CTL |-> (rd_data & ~`LOR_USED_MASK) == 8'h00)
        and (rd_addr == `ADDR_SWALLOW |-> (rd_data & ~`SWALLOW_USED_MASK) == 8'h00))
        else $error("unused bits read back as one");
    lor_disabled_a: assert property (@(posedge core_clk) disable iff (reset)
        !c.img.lor_en |=> !reference_loss_detect)
        else $error("reference loss detection on while disabled");
    lor_wait_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(c.armed) |-> c.arm_cnt == delay_cycles(c.img.lor_delay) && c.lock_seen)
        else $error("reference loss detection armed after the wrong wait");
    lor_early_a: assert property (@(posedge core_clk) disable iff (reset)
        (c.img.lor_en && !c.armed) |-> c.arm_cnt < delay_cycles(c.img.lor_delay))
        else $error("wait counter ran past the selected delay");
    pump_follow_a: assert property (@(posedge core_clk) disable iff (reset)
        (c.tog_s3 != c.tog_s2) |=> pump_mode == pump_mode_t'(c.img.pump_ctl[`PUMP_MODE_MSB:0])
            && c.img == $past(l.regs))
        else $error("pump mode did not follow the captured image");
endmodule : pll_serial_config_registers

// file: hdl/serial_frame_engine.sv
// serial frame engine: instruction decode, data shifting and read-back drive on the serial clock
`timescale 1ns/100ps
module serial_frame_engine
    import pll_cfg_pkg::*;
(
    input wire logic sclk,
    input wire logic select_n,
    input wire logic sdio_in,
    input wire port_mode_t mode,
    input wire logic [7:0] rd_data,
    output logic [12:0] rd_addr,
    output reg_write_t wr,
    output serial_drive_t drv
);
    function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [3:0] last, input logic lsb);
        return lsb ? idx : 4'(last - idx);
    endfunction : bit_pos

    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
        return lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
    endfunction : step_addr

    frame_t s;
    frame_t next_s;
    logic [3:0] last;
    logic [3:0] cnt_inc;
    logic [3:0] pos;
    logic [3:0] rpos;
    logic [15:0] ins;
    logic [7:0] db;
    logic dec_rw;
    logic [1:0] dec_w;
    logic [12:0] dec_addr;
    logic byte_end;

    always_comb begin
        last = mode.long_insn ? `INSN_LONG_LAST : `INSN_SHORT_LAST;
        cnt_inc = 4'(s.cnt + 4'h1);
        ins = s.insn;
        ins[bit_pos(s.cnt, last, mode.lsb_first)] = sdio_in;
        db = s.dbyte;
        pos = bit_pos(s.cnt, `BYTE_LAST, mode.lsb_first);
        db[pos[2:0]] = sdio_in;
        dec_rw = mode.long_insn ? ins[`LONG_RW_BIT] : ins[`SHORT_RW_BIT];
        dec_w = mode.long_insn ? ins[`LONG_W_MSB:`LONG_W_LSB] : ins[`SHORT_W_MSB:`SHORT_W_LSB];
        dec_addr = mode.long_insn ? ins[`LONG_ADDR_MSB:0] : {8'h00, ins[`SHORT_ADDR_MSB:0]};
        byte_end = (s.phase == ST_DATA) && (s.cnt == `BYTE_LAST);
        if (s.phase == ST_INSN) begin
            rd_addr = dec_addr;
        end else if (byte_end) begin
            rd_addr = step_addr(s.addr, mode.lsb_first);
        end else begin
            rd_addr = s.addr;
        end
        wr.valid = byte_end && !s.is_read;
        wr.addr = s.addr;
        wr.data = db;
        // the first bit of each byte goes out on the edge that ends the instruction or the previous byte
        rpos = bit_pos((byte_end || s.phase == ST_INSN) ? 4'h0 : cnt_inc, `BYTE_LAST, mode.lsb_first);
        next_s = s;
        unique case (s.phase)
            ST_INSN: begin
                next_s.insn = ins;
                next_s.cnt = cnt_inc;
                if (s.cnt == last) begin
                    next_s.phase = ST_DATA;
                    next_s.cnt = 4'h0;
                    next_s.addr = dec_addr;
                    next_s.is_read = dec_rw;
                    next_s.stream = (dec_w == `STREAM_CODE);
                    next_s.left = dec_w;
                    next_s.drv.out = rd_data[rpos[2:0]];
                    next_s.drv.sdo_oe = dec_rw && !mode.bidir;
                    next_s.drv.sdio_oe = dec_rw && mode.bidir;
                end
            end
            ST_DATA: begin
                next_s.dbyte = db;
                next_s.cnt = cnt_inc;
                next_s.drv.out = rd_data[rpos[2:0]];
                if (byte_end) begin
                    next_s.cnt = 4'h0;
                    next_s.addr = step_addr(s.addr, mode.lsb_first);
                    if (!s.stream && s.left == 2'h0) begin
                        next_s.phase = ST_DONE;
                        next_s.drv = '0;
                    end else if (!s.stream) begin
                        next_s.left = 2'(s.left - 2'h1);
                    end
                end
            end
            ST_DONE: begin
            end
            default: next_s = '0;
        endcase
    end

    // the frame state clears while select is high; the serial clock need not run then
    always_ff @(posedge sclk or posedge select_n) begin
        if (select_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign drv = s.drv;

    short_insn_a: assert property (@(posedge sclk) disable iff (select_n)
        (s.phase == ST_INSN && s.cnt == 4'h7 && !mode.long_insn) |=> s.phase == ST_DATA)
        else $error("short instruction did not end after eight bits");
    long_insn_a: assert property (@(posedge sclk) disable iff (select_n)
        (s.phase == ST_INSN && s.cnt == 4'h7 && mode.long_insn) |=> s.phase == ST_INSN)
        else $error("long instruction ended after eight bits");
    bit_order_a: assert property (@(posedge sclk) disable iff (select_n)
        wr.valid |-> wr.data[mode.lsb_first ? 3'h7 : 3'h0] == sdio_in)
        else $error("last data bit landed at the wrong end of the byte");
    sdo_inactive_a: assert property (@(posedge sclk) disable iff (select_n)
        $rose(drv.sdo_oe || drv.sdio_oe) |-> drv.sdio_oe == $past(mode.bidir) && drv.sdo_oe == !$past(mode.bidir))
        else $error("read data driven on the wrong pin");
endmodule : serial_frame_engine
